/* include/uhc_consts.vh */
// Purpose: Shared constants of the USB host control and interrupt block
// Assumes: Included by bare name from the host control design file of the block
// Notes:   Definitions only
`ifndef UHC_CONSTS_VH
`define UHC_CONSTS_VH

// Register offsets, reached through the pointer loaded by an address write
`define UHC_OFS_PKT_A    8'h01
`define UHC_OFS_PKT_B    8'h09
`define UHC_OFS_CTRL1    8'h05
`define UHC_OFS_IEN      8'h06
`define UHC_OFS_SADDR    8'h07
`define UHC_OFS_ISTAT    8'h0D
`define UHC_OFS_SOFLO    8'h0E
`define UHC_OFS_SOFHI    8'h0F

// Reset and writable-bit masks
`define UHC_RST_BYTE     8'h00
`define UHC_CTRL1_MASK   8'h79
`define UHC_IEN_MASK     8'h73
`define UHC_RSVD_BITS    2'h0

// Control one bits
`define UHC_B_SOF_EN     0
`define UHC_B_FORCE_LO   3
`define UHC_B_FORCE_HI   4
`define UHC_B_SPEED      5
`define UHC_B_SUSPEND    6

// Control two bits, written at the high counter offset
`define UHC_B_POLSWAP    6
`define UHC_SOFHI_W      6

// Interrupt enable and status bits
`define UHC_B_DONE_A     0
`define UHC_B_DONE_B     1
`define UHC_B_SOFT       4
`define UHC_B_INSERT     5
`define UHC_B_DETECT     6
`define UHC_B_DPLUS      7

// Line force codes
`define UHC_FORCE_NORM   2'h0
`define UHC_FORCE_SE0    2'h1
`define UHC_FORCE_J      2'h2
`define UHC_FORCE_K      2'h3

// Start-of-frame timer, frame number and CRC5
`define UHC_CNT_W        14
`define UHC_CNT_SHIFT    6
`define UHC_CNT_ZERO     14'h0000
`define UHC_CNT_ONE      14'h0001
`define UHC_FRAME_W      11
`define UHC_FRAME_ZERO   11'h000
`define UHC_FRAME_ONE    11'h001
`define UHC_CRC5_INIT    5'h1F
`define UHC_CRC5_POLY    5'h05

`endif

/* logic/uhc_sticky_flag.v */
// Purpose: One sticky interrupt flag, set by hardware, cleared by software
// Assumes: Set and clear are one-cycle pulses on ref_clk
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module uhc_sticky_flag
(
   input  wire ref_clk,
   input  wire sys_rst,
   input  wire set_evt,
   input  wire clr_req,
   output wire flag_q
);

   reg flag_r;

   // Holds until cleared; an event beside a clear is not lost
   always @(posedge ref_clk)
   begin
      if (sys_rst)
         flag_r <= 1'b0;
      else if (set_evt)
         flag_r <= 1'b1;
      else if (clr_req)
         flag_r <= 1'b0;
   end

   assign flag_q = flag_r;

endmodule // uhc_sticky_flag
`default_nettype wire

/* logic/uhc_host_ctrl.v */
// Purpose: Host control, line force, SOF timer and interrupt logic
// Assumes: CPU strobes and USB line inputs are synchronous to ref_clk
// Notes:   Timer ticks once per ref_clk, the reload sets the frame length
//
// Behaviour
// - Suspend powers down transmitter, RAM, clocks
// - Bus K state while suspended resumes operation
// - Lone data write wakes device from suspend
// - Speed bit resets to full speed
// - Speed plus polarity swap serves direct low-speed
// - Line force codes drive normal, SE0, J, K
// - Low speed exchanges forced J and K
// - Line force clears at reset
// - SOF generation active after bus reset
// - Hardware makes frame number and CRC5
// - Status flags set regardless of enables
// - Level interrupt until enabled flags cleared
// - Enable bit 6 gates resume or detect
// - Enable bit 5 gates insert/remove interrupt
// - SOF interrupt needs enable and loaded counters
// - Channel done sets flag and packet status
// - Writing ones clears status flags
// - Channel B behaves like channel A
// - Insert/remove flag on SE0 edges
// - Status bit 7 shows live D+
// - Status bit 6 resume flag or absence
`timescale 1ns/10ps
`default_nettype none
`include "uhc_consts.vh"
module uhc_host_ctrl
#(
   parameter [3:0] HW_REV = 4'h6  // Arbitrary revision code
)
(
   input  wire       ref_clk,
   input  wire       sys_rst,
   input  wire       cpu_cs_n,
   input  wire       cpu_wr_n,
   input  wire       cpu_rd_n,
   input  wire       addr_phase_select,
   input  wire [7:0] cpu_data_in,
   output reg  [7:0] cpu_data_out,
   output wire       cpu_data_oe,
   output wire       cpu_irq_out,
   input  wire       usb_dp_in,
   input  wire       usb_dm_in,
   output reg        usb_dp_out,
   output reg        usb_dm_out,
   output reg        usb_line_oe,
   input  wire       chan_a_done,
   input  wire [7:0] chan_a_status,
   input  wire       chan_b_done,
   input  wire [7:0] chan_b_status,
   output wire       xcvr_tx_pwr_down,
   output wire       ram_suspend,
   output wire       int_clk_stop,
   output reg        sof_token_valid,
   output reg  [10:0] sof_frame_out,
   output reg  [4:0] sof_crc5_out
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   reg  [7:0]  ptr_r;
   reg         ptr_armed_r;
   reg         wr_prev_r;
   reg         rd_prev_r;
   reg  [7:0]  ctrl1_r;
   reg  [7:0]  ctrl1_nxt;
   reg  [7:0]  ien_r;
   reg  [7:0]  sof_lo_r;
   reg  [5:0]  sof_hi_r;
   reg         polswap_r;
   reg         lo_loaded_r;
   reg         hi_loaded_r;
   reg  [13:0] cnt_r;
   reg  [10:0] frame_r;
   reg         sof_tick_r;
   reg         se0_prev_r;
   reg  [7:0]  pkt_a_r;
   reg  [7:0]  pkt_b_r;
   reg  [7:0]  rd_mux;
   reg  [7:0]  stat_view;
   reg  [7:0]  irq_view;
   reg         drv_dp;
   reg         drv_dm;

   wire        wr_act;
   wire        rd_act;
   wire        wr_take;
   wire        rd_take;
   wire        addr_wr;
   wire        data_wr;
   wire        data_rd;
   wire        wake_wr;
   wire        reg_wr;
   wire        suspended;
   wire        low_speed;
   wire [1:0]  force_code;
   wire        dp_s;
   wire        dm_s;
   wire        se0_now;
   wire        kstate;
   wire        bus_resume;
   wire        timer_run;
   wire [13:0] reload;
   wire        stat_clr;
   wire        flag_done_a;
   wire        flag_done_b;
   wire        flag_sof;
   wire        flag_insert;
   wire        flag_resume;

   ////////////////////////////////////////////////////////////////////////
   // CRC5 over the frame number, bit 0 first, result inverted

   function [4:0] uhc_crc5;
      input [10:0] data_in;
      integer      i;
      reg   [4:0]  crc;
      reg          fb;
      begin
         crc = `UHC_CRC5_INIT;
         for (i = 0; i < `UHC_FRAME_W; i = i + 1)
         begin
            fb  = data_in[i] ^ crc[4];
            crc = {crc[3:0], 1'b0};
            if (fb)
               crc = crc ^ `UHC_CRC5_POLY;
         end
         uhc_crc5 = ~crc;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // CPU port: address phase loads the pointer, data phase accesses

   // Strobes counted once, on their first active cycle
   assign wr_act  = ~cpu_cs_n & ~cpu_wr_n;
   assign rd_act  = ~cpu_cs_n & ~cpu_rd_n;
   assign wr_take = wr_act & ~wr_prev_r;
   assign rd_take = rd_act & ~rd_prev_r;
   assign addr_wr = wr_take & ~addr_phase_select;
   assign data_wr = wr_take & addr_phase_select;
   assign data_rd = rd_take & addr_phase_select;

   // lone data write
   // A data write with no address write before it, while suspended, only wakes the device
   assign wake_wr = data_wr & ~ptr_armed_r & suspended;
   assign reg_wr  = data_wr & ~wake_wr;

   // Strobe history and pointer state
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wr_prev_r   <= 1'b0;
         rd_prev_r   <= 1'b0;
         ptr_r       <= `UHC_RST_BYTE;
         ptr_armed_r <= 1'b0;
      end
      else
      begin
         wr_prev_r <= wr_act;
         rd_prev_r <= rd_act;
         if (addr_wr)
         begin
            ptr_r       <= cpu_data_in;
            ptr_armed_r <= 1'b1;
         end
         else if (data_wr | data_rd)
            ptr_armed_r <= 1'b0;
      end
   end

   // Data bus drive follows the read strobe
   assign cpu_data_oe = rd_act & addr_phase_select;

   ////////////////////////////////////////////////////////////////////////
   // Control one: suspend, speed, line force, SOF enable

   assign suspended  = ctrl1_r[`UHC_B_SUSPEND];
   assign low_speed  = ctrl1_r[`UHC_B_SPEED];
   assign force_code = ctrl1_r[`UHC_B_FORCE_HI:`UHC_B_FORCE_LO];

   // Next value: CPU write, then wake-up clears suspend
   always @*
   begin
      ctrl1_nxt = ctrl1_r;
      if (reg_wr && ptr_r == `UHC_OFS_CTRL1)
         ctrl1_nxt = cpu_data_in & `UHC_CTRL1_MASK;
      if (wake_wr | bus_resume)
         ctrl1_nxt[`UHC_B_SUSPEND] = 1'b0;
   end

   always @(posedge ref_clk)
   begin
      if (sys_rst)
         ctrl1_r <= `UHC_RST_BYTE;
      else
         ctrl1_r <= ctrl1_nxt;
   end

   // suspend power down
   // The SOF timer, tokens and line drive stop while these are high; the wake detectors keep running
   assign xcvr_tx_pwr_down = suspended;
   assign ram_suspend      = suspended;
   assign int_clk_stop     = suspended;

   ////////////////////////////////////////////////////////////////////////
   // Enable, control two and SOF counter registers

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ien_r       <= `UHC_RST_BYTE;
         sof_lo_r    <= `UHC_RST_BYTE;
         sof_hi_r    <= {`UHC_SOFHI_W{1'b0}};
         polswap_r   <= 1'b0;
         lo_loaded_r <= 1'b0;
         hi_loaded_r <= 1'b0;
         pkt_a_r     <= `UHC_RST_BYTE;
         pkt_b_r     <= `UHC_RST_BYTE;
      end
      else
      begin
         if (reg_wr && ptr_r == `UHC_OFS_IEN)
            ien_r <= cpu_data_in & `UHC_IEN_MASK;
         if (reg_wr && ptr_r == `UHC_OFS_SOFLO)
         begin
            sof_lo_r    <= cpu_data_in;
            lo_loaded_r <= 1'b1;
         end
         if (reg_wr && ptr_r == `UHC_OFS_SOFHI)
         begin
            sof_hi_r    <= cpu_data_in[`UHC_SOFHI_W-1:0];
            polswap_r   <= cpu_data_in[`UHC_B_POLSWAP];
            hi_loaded_r <= 1'b1;
         end
         if (chan_a_done)
            pkt_a_r <= chan_a_status;
         if (chan_b_done)
            pkt_b_r <= chan_b_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus line sensing

   assign dp_s    = polswap_r ? usb_dm_in : usb_dp_in;
   assign dm_s    = polswap_r ? usb_dp_in : usb_dm_in;
   assign se0_now = ~usb_dp_in & ~usb_dm_in;
   assign kstate  = ~dp_s & dm_s;

   // K state wakes
   // Own forced K must not count as activity from the bus
   assign bus_resume = suspended & kstate & ~usb_line_oe;

   // SE0 history for attach and detach edges
   always @(posedge ref_clk)
   begin
      if (sys_rst)
         se0_prev_r <= 1'b1;
      else
         se0_prev_r <= se0_now;
   end

   ////////////////////////////////////////////////////////////////////////
   // Line force drive

   always @*
   begin
      case (force_code)
         `UHC_FORCE_SE0:
         begin
            drv_dp = 1'b0;
            drv_dm = 1'b0;
         end
         `UHC_FORCE_J:
         begin
            drv_dp = ~low_speed;
            drv_dm = low_speed;
         end
         `UHC_FORCE_K:
         begin
            drv_dp = low_speed;
            drv_dm = ~low_speed;
         end
         default:
         begin
            drv_dp = 1'b0;
            drv_dm = 1'b0;
         end
      endcase
   end

   // Registered pins; no drive in normal mode or suspend
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         usb_dp_out  <= 1'b0;
         usb_dm_out  <= 1'b0;
         usb_line_oe <= 1'b0;
      end
      else
      begin
         usb_dp_out  <= drv_dp;
         usb_dm_out  <= drv_dm;
         usb_line_oe <= (force_code != `UHC_FORCE_NORM) & ~suspended;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // SOF timer and frame counter

   assign reload    = {sof_hi_r, sof_lo_r};
   assign timer_run = lo_loaded_r & hi_loaded_r & ~suspended;

   // frame number in hardware
   // Writing the high counter restarts the frame and the count
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cnt_r      <= `UHC_CNT_ZERO;
         frame_r    <= `UHC_FRAME_ZERO;
         sof_tick_r <= 1'b0;
      end
      else if (reg_wr && ptr_r == `UHC_OFS_SOFHI)
      begin
         cnt_r      <= {cpu_data_in[`UHC_SOFHI_W-1:0], sof_lo_r};
         frame_r    <= `UHC_FRAME_ZERO;
         sof_tick_r <= 1'b0;
      end
      else if (timer_run && cnt_r == `UHC_CNT_ZERO)
      begin
         cnt_r      <= reload;
         frame_r    <= frame_r + `UHC_FRAME_ONE;
         sof_tick_r <= 1'b1;
      end
      else
      begin
         if (timer_run)
            cnt_r <= cnt_r - `UHC_CNT_ONE;
         sof_tick_r <= 1'b0;
      end
   end

   // CRC5 in hardware
   // Tokens held back while forced or suspended; the timer keeps counting while forced and stops in suspend
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sof_token_valid <= 1'b0;
         sof_frame_out   <= `UHC_FRAME_ZERO;
         sof_crc5_out    <= `UHC_CRC5_INIT;
      end
      else
      begin
         sof_token_valid <= sof_tick_r & ctrl1_r[`UHC_B_SOF_EN] & ~suspended &
                            (force_code == `UHC_FORCE_NORM);
         if (sof_tick_r)
         begin
            sof_frame_out <= frame_r - `UHC_FRAME_ONE;
            sof_crc5_out  <= uhc_crc5(frame_r - `UHC_FRAME_ONE);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt flags

   assign stat_clr = reg_wr && ptr_r == `UHC_OFS_ISTAT;

   uhc_sticky_flag u_flag_done_a
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_evt (chan_a_done),
      .clr_req (stat_clr & cpu_data_in[`UHC_B_DONE_A]),
      .flag_q  (flag_done_a)
   );

   uhc_sticky_flag u_flag_done_b
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_evt (chan_b_done),
      .clr_req (stat_clr & cpu_data_in[`UHC_B_DONE_B]),
      .flag_q  (flag_done_b)
   );

   uhc_sticky_flag u_flag_sof
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_evt (sof_tick_r & ctrl1_r[`UHC_B_SOF_EN]),
      .clr_req (stat_clr & cpu_data_in[`UHC_B_SOFT]),
      .flag_q  (flag_sof)
   );

   uhc_sticky_flag u_flag_insert
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_evt (se0_now ^ se0_prev_r),
      .clr_req (stat_clr & cpu_data_in[`UHC_B_INSERT]),
      .flag_q  (flag_insert)
   );

   uhc_sticky_flag u_flag_resume
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_evt (bus_resume),
      .clr_req (stat_clr & cpu_data_in[`UHC_B_DETECT]),
      .flag_q  (flag_resume)
   );

   always @*
   begin
      stat_view = {usb_dp_in,
                   suspended ? flag_resume : se0_now,
                   flag_insert, flag_sof, `UHC_RSVD_BITS,
                   flag_done_b, flag_done_a};
      // Bit 7 is a live level, never an interrupt source
      irq_view = stat_view;
      irq_view[`UHC_B_DPLUS] = 1'b0;
   end

   assign cpu_irq_out = |(irq_view & ien_r);

   ////////////////////////////////////////////////////////////////////////
   // Read data

   // Read mux; unmapped offsets read zero
   always @*
   begin
      case (ptr_r)
         `UHC_OFS_PKT_A: rd_mux = pkt_a_r;
         `UHC_OFS_PKT_B: rd_mux = pkt_b_r;
         `UHC_OFS_CTRL1: rd_mux = ctrl1_r;
         `UHC_OFS_IEN:   rd_mux = ien_r;
         `UHC_OFS_ISTAT: rd_mux = stat_view;
         `UHC_OFS_SOFLO: rd_mux = {HW_REV, 4'h0};
         `UHC_OFS_SOFHI: rd_mux = cnt_r[`UHC_CNT_W-1:`UHC_CNT_SHIFT];
         default:        rd_mux = `UHC_RST_BYTE;
      endcase
   end

   // Registered read data, refreshed every cycle
   always @(posedge ref_clk)
   begin
      if (sys_rst)
         cpu_data_out <= `UHC_RST_BYTE;
      else
         cpu_data_out <= rd_mux;
   end

endmodule // uhc_host_ctrl
`default_nettype wire

/* sim/uhc_host_ctrl_chk.sv */
// Purpose: Port-level assertions for the host control block
// Assumes: Sees only top module ports, one clock domain
// Notes:   Bound to uhc_host_ctrl at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module uhc_host_ctrl_chk
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        cpu_cs_n,
   input wire logic        cpu_wr_n,
   input wire logic        cpu_rd_n,
   input wire logic        addr_phase_select,
   input wire logic        cpu_irq_out,
   input wire logic        usb_dp_in,
   input wire logic        usb_dm_in,
   input wire logic        usb_dp_out,
   input wire logic        usb_dm_out,
   input wire logic        usb_line_oe,
   input wire logic        xcvr_tx_pwr_down,
   input wire logic        ram_suspend,
   input wire logic        int_clk_stop,
   input wire logic        sof_token_valid,
   input wire logic [10:0] sof_frame_out,
   input wire logic [4:0]  sof_crc5_out
);
   default clocking dflt_cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic        acc_r, addr_r, seen_r, dp_r, dm_r;
   logic [2:0]  quiet_r;
   logic [10:0] frame_r;
   wire         acc_w  = !cpu_cs_n && !(cpu_wr_n && cpu_rd_n);
   wire         take_w = acc_w && !acc_r;
   ////////////////////////////////////////////////////////////////////////
   // Access edges, pending pointer load, quiet time and last frame sent
   always @(posedge ref_clk)
   begin
      if (sys_rst)
         {acc_r, addr_r, seen_r, dp_r, dm_r, quiet_r} <= 8'h00;
      else
      begin
         acc_r  <= acc_w;
         dp_r   <= usb_dp_in;
         dm_r   <= usb_dm_in;
         seen_r <= !take_w && (seen_r || sof_token_valid);
         if (take_w)
            addr_r <= !addr_phase_select;
         // Line changes and accesses move the flags, so wait out several quiet cycles
         if (acc_w || dp_r != usb_dp_in || dm_r != usb_dm_in)
            quiet_r <= 3'h0;
         else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
         if (sof_token_valid)
            frame_r <= sof_frame_out;
      end
   end
   // Inverted USB CRC5 remainder, frame bits taken LSB first
   function automatic logic [4:0] crc5_of(input logic [10:0] d);
      logic [4:0] c;
      begin
         c = 5'h1F;
         for (int k = 0; k < 11; k++)
            c = {c[3:0], 1'b0} ^ ((d[k] ^ c[4]) ? 5'h05 : 5'h00);
         return ~c;
      end
   endfunction
   sequence lone_wr_s;
      xcvr_tx_pwr_down && take_w && !cpu_wr_n && addr_phase_select && !addr_r;
   endsequence
   sequence tok_s;
      sof_token_valid && seen_r;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   susp_outs_a:
   assert property (xcvr_tx_pwr_down == ram_suspend &&
                    ram_suspend == int_clk_stop)
      else $error("suspend outputs disagree");
   susp_quiet_a:
   assert property (xcvr_tx_pwr_down [*2] |-> !usb_line_oe && !sof_token_valid)
      else $error("line driven while suspended");
   lone_wake_a:
   assert property (lone_wr_s |-> ##[1:2] !xcvr_tx_pwr_down)
      else $error("lone data write did not wake");
   no_se1_a:
   assert property (usb_line_oe |-> !(usb_dp_out && usb_dm_out))
      else $error("both lines forced high");
   sof_gap_a:
   assert property (usb_line_oe && $past(usb_line_oe) |-> !sof_token_valid)
      else $error("start of frame during forced line");
   sof_pulse_a:
   assert property (sof_token_valid |=> !sof_token_valid)
      else $error("token strobe longer than one cycle");
   sof_crc_a:
   assert property (sof_token_valid |-> sof_crc5_out == crc5_of(sof_frame_out))
      else $error("frame check bits wrong");
   frame_step_a:
   assert property (tok_s |-> sof_frame_out == frame_r + 11'h001)
      else $error("frame number did not step by one");
   irq_hold_a:
   assert property ($past(cpu_irq_out) && quiet_r == 3'h7 &&
                    usb_dp_in == dp_r && usb_dm_in == dm_r |-> cpu_irq_out)
      else $error("interrupt dropped with no clear");
endmodule // uhc_host_ctrl_chk
bind uhc_host_ctrl uhc_host_ctrl_chk chk_u
(
   .ref_clk(ref_clk), .sys_rst(sys_rst), .cpu_cs_n(cpu_cs_n),
   .cpu_wr_n(cpu_wr_n), .cpu_rd_n(cpu_rd_n),
   .addr_phase_select(addr_phase_select), .cpu_irq_out(cpu_irq_out),
   .usb_dp_in(usb_dp_in), .usb_dm_in(usb_dm_in), .usb_dp_out(usb_dp_out),
   .usb_dm_out(usb_dm_out), .usb_line_oe(usb_line_oe),
   .xcvr_tx_pwr_down(xcvr_tx_pwr_down), .ram_suspend(ram_suspend),
   .int_clk_stop(int_clk_stop), .sof_token_valid(sof_token_valid),
   .sof_frame_out(sof_frame_out), .sof_crc5_out(sof_crc5_out)
);
`default_nettype wire

/* sim/uhc_usb_dev_model.sv */
// Purpose: USB peripheral as seen on the host lines
// Assumes: Host drive wins while its line enable is high
// Notes:   Host pull-downs give SE0 when detached
`timescale 1ns/10ps
`default_nettype none
module uhc_usb_dev_model
(
   input  wire logic attach,
   input  wire logic send_k,
   input  wire logic host_oe,
   input  wire logic host_dp,
   input  wire logic host_dm,
   output logic      line_dp,
   output logic      line_dm
);
   // Resolve the wire: host first, then pull-downs when detached, then device
   always @*
   begin
      if (host_oe)
         {line_dp, line_dm} = {host_dp, host_dm};
      else if (!attach)
         {line_dp, line_dm} = 2'h0;
      else if (send_k)
         {line_dp, line_dm} = 2'h1;
      else
         {line_dp, line_dm} = 2'h2;
   end
endmodule // uhc_usb_dev_model
`default_nettype wire

/* sim/tb.sv */
// Purpose: Self-checking bench for the host control block
// Assumes: Inputs change on the falling edge of ref_clk
// Notes:   A monitor pops the oldest expected byte at each sample
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        ref_clk, sys_rst, cpu_cs_n, cpu_wr_n, cpu_rd_n, cpu_data_oe;
   logic        addr_phase_select, cpu_irq_out, usb_dp_in, usb_dm_in;
   logic        usb_dp_out, usb_dm_out, usb_line_oe, chan_a_done, chan_b_done;
   logic        xcvr_tx_pwr_down, ram_suspend, int_clk_stop, sof_token_valid;
   logic        dev_attach, dev_k, mon_take, tok_win;
   logic [1:0]  mon_sel;
   logic [4:0]  sof_crc5_out;
   logic [7:0]  cpu_data_in, cpu_data_out, chan_a_status, chan_b_status;
   logic [7:0]  tok_n, rnd, ex;
   logic [10:0] sof_frame_out;
   logic [7:0]  exp_q[$];
   integer      num_errors, cmp_count, seed, i;
   // Line outputs only count while driven
   wire  [7:0]  obs_w = {cpu_irq_out, usb_line_oe, usb_dp_out & usb_line_oe,
                         usb_dm_out & usb_line_oe, xcvr_tx_pwr_down,
                         ram_suspend, int_clk_stop, cpu_data_oe};
   uhc_host_ctrl dut_u
   (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .cpu_cs_n(cpu_cs_n),
      .cpu_wr_n(cpu_wr_n), .cpu_rd_n(cpu_rd_n),
      .addr_phase_select(addr_phase_select), .cpu_data_in(cpu_data_in),
      .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
      .cpu_irq_out(cpu_irq_out), .usb_dp_in(usb_dp_in), .usb_dm_in(usb_dm_in),
      .usb_dp_out(usb_dp_out), .usb_dm_out(usb_dm_out),
      .usb_line_oe(usb_line_oe), .chan_a_done(chan_a_done),
      .chan_a_status(chan_a_status), .chan_b_done(chan_b_done),
      .chan_b_status(chan_b_status), .xcvr_tx_pwr_down(xcvr_tx_pwr_down),
      .ram_suspend(ram_suspend), .int_clk_stop(int_clk_stop),
      .sof_token_valid(sof_token_valid), .sof_frame_out(sof_frame_out),
      .sof_crc5_out(sof_crc5_out)
   );
   uhc_usb_dev_model dev_u
   (
      .attach(dev_attach), .send_k(dev_k), .host_oe(usb_line_oe),
      .host_dp(usb_dp_out), .host_dm(usb_dm_out), .line_dp(usb_dp_in),
      .line_dm(usb_dm_in)
   );
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic tally_and_finish;
      begin
         $display("compares %0d errors %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
      begin
         cmp_count = cmp_count + 1;
         if (got !== want)
         begin
            num_errors = num_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
         end
      end
   endtask
   // Monitor: token count over a window, and the oldest note per sample
   always @(posedge ref_clk)
   begin
      if (tok_win === 1'b1)
         tok_n <= tok_n + {7'h00, sof_token_valid === 1'b1};
      else
         tok_n <= 8'h00;
      if (mon_take === 1'b1)
         cmp8(mon_sel == 2'h2 ? tok_n : mon_sel == 2'h1 ? obs_w : cpu_data_out,
              exp_q.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic probe(input logic [1:0] sel, input logic [7:0] want,
                        input integer pre);
      begin
         repeat (pre) @(negedge ref_clk);
         exp_q.push_back(want);
         mon_sel = sel;
         mon_take = 1'b1;
         @(negedge ref_clk);
         mon_take = 1'b0;
      end
   endtask
   // One strobe held three cycles, then released for at least one
   task automatic bus(input logic wr, input logic ph, input logic [7:0] d,
                      input logic chk, input logic [7:0] want);
      begin
         @(negedge ref_clk);
         cpu_cs_n = 1'b0;
         cpu_wr_n = !wr;
         cpu_rd_n = wr;
         addr_phase_select = ph;
         cpu_data_in = d;
         repeat (2) @(negedge ref_clk);
         if (chk)
            probe(2'h0, want, 0);
         else
            @(negedge ref_clk);
         {cpu_cs_n, cpu_wr_n, cpu_rd_n} = 3'h7;
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      begin
         bus(1'b1, 1'b0, a, 1'b0, 8'h00);
         bus(1'b1, 1'b1, d, 1'b0, 8'h00);
      end
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] want);
      begin
         bus(1'b1, 1'b0, a, 1'b0, 8'h00);
         bus(1'b0, 1'b1, 8'h00, 1'b1, want);
      end
   endtask
   // Both status inputs move; only the pulsed channel may capture
   task automatic done(input logic b, input logic [7:0] s);
      begin
         @(negedge ref_clk);
         chan_a_status = s;
         chan_b_status = s;
         {chan_b_done, chan_a_done} = {b, !b};
         @(negedge ref_clk);
         {chan_b_done, chan_a_done} = 2'h0;
      end
   endtask
   task automatic toks(input logic [7:0] want);
      begin
         tok_win = 1'b1;
         repeat (320) @(negedge ref_clk);
         tok_win = 1'b0;
         probe(2'h2, want, 0);
      end
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors = num_errors + 1;
      tally_and_finish;
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {seed, num_errors, cmp_count} = {32'hBB8C, 64'h0};
      {sys_rst, cpu_cs_n, cpu_wr_n, cpu_rd_n} = 4'hF;
      {addr_phase_select, chan_a_done, chan_b_done, dev_attach} = 4'h0;
      {dev_k, mon_take, mon_sel, tok_win, cpu_data_in} = 13'h0000;
      {chan_a_status, chan_b_status} = 16'h0000;
      repeat (4) @(negedge ref_clk);
      sys_rst = 1'b0;
      rreg(8'h05, 8'h00);
      rreg(8'h06, 8'h00);
      rreg(8'h0D, 8'h40);
      rreg(8'h07, 8'h00);
      wreg(8'h06, 8'hFF);
      rreg(8'h06, 8'h73);
      wreg(8'h05, 8'h87);
      rreg(8'h05, 8'h01);
      wreg(8'h06, 8'h00);
      dev_attach = 1'b1;
      rreg(8'h0D, 8'hA0);
      probe(2'h1, 8'h00, 0);
      wreg(8'h06, 8'h20);
      probe(2'h1, 8'h80, 2);
      wreg(8'h0D, 8'h00);
      probe(2'h1, 8'h80, 2);
      wreg(8'h0D, 8'h20);
      probe(2'h1, 8'h00, 2);
      wreg(8'h06, 8'h40);
      probe(2'h1, 8'h00, 2);
      dev_attach = 1'b0;
      probe(2'h1, 8'h80, 6);
      dev_attach = 1'b1;
      wreg(8'h0D, 8'h60);
      wreg(8'h06, 8'h03);
      rnd = 8'($random(seed));
      done(1'b0, rnd);
      ex = 8'($random(seed));
      done(1'b1, ex);
      rreg(8'h01, rnd);
      rreg(8'h09, ex);
      wreg(8'h0D, 8'h01);
      probe(2'h1, 8'h80, 2);
      rreg(8'h0D, 8'h82);
      wreg(8'h0D, 8'h02);
      probe(2'h1, 8'h00, 2);
      // Every force code at both speeds; code one is the bus reset
      for (i = 0; i < 8; i = i + 1)
      begin
         wreg(8'h05, {2'h0, i[2:0], 3'h0});
         ex = (i[1:0] == 2'h0) ? 8'h00 : (i[1:0] == 2'h1) ? 8'h40 :
              ((i[0] ^ i[2]) ? 8'h50 : 8'h60);
         probe(2'h1, ex, 2);
      end
      wreg(8'h05, 8'h00);
      wreg(8'h0E, 8'h1F);
      wreg(8'h0F, 8'h00);
      wreg(8'h05, 8'h01);
      toks(8'h0A);
      wreg(8'h06, 8'h10);
      probe(2'h1, 8'h80, 0);
      wreg(8'h06, 8'h00);
      wreg(8'h05, 8'h09);
      toks(8'h00);
      wreg(8'h05, 8'h01);
      toks(8'h0A);
      wreg(8'h05, 8'h40);
      probe(2'h1, 8'h0E, 2);
      bus(1'b1, 1'b1, 8'h20, 1'b0, 8'h00);
      probe(2'h1, 8'h00, 2);
      rreg(8'h05, 8'h00);
      wreg(8'h05, 8'h40);
      dev_k = 1'b1;
      probe(2'h1, 8'h00, 6);
      dev_k = 1'b0;
      wreg(8'h0F, 8'h40);
      wreg(8'h05, 8'h40);
      probe(2'h1, 8'h00, 2);
      tally_and_finish;
   end
endmodule // tb
`default_nettype wire
